// [rtl/tdsm_core.v]
/*
  Table driven Moore state machine with an APB loaded transition table.
  Assumes synchronous inputs on pclk and a well formed table written by software.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
// What this block does
// - States are numbered from zero and each state has exactly one definition slot.
// - Each state definition is a leading entry plus any number of further transition entries.
// - Every entry maps an input pattern to a destination state entered on the next clock.
// - A per-state output value register, not the leading entry, fixes the output value while in that state.
// - Each output bit carries a level of 0, 1 or unknown and a drive of strong, resistive, high-z or undefined.
// - Hardware reset forces state zero; sm_reset and the control soft reset force a configurable default state.
// - All state, output and transition behaviour comes from the loaded table.
`timescale 1ns/100ps
`include "tdsm_map.vh"
module tdsm_core (
  // Clock, enable and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Machine pins
  input  wire [`TDSM_NUM_IN-1:0]  sm_in,
  input  wire                     sm_reset,
  output reg  [`TDSM_NUM_OUT-1:0] out_level,
  output reg  [`TDSM_NUM_OUT-1:0] out_unknown,
  output reg  [2*`TDSM_NUM_OUT-1:0] out_drive,
  output reg  [`TDSM_STATE_W-1:0] present_state_index
);
  localparam OVW = `TDSM_OV_SLOT * `TDSM_NUM_OUT;
  // Table storage
  reg [31:0]            ent_q [0:`TDSM_NUM_ENT-1];
  reg [OVW-1:0]         outv_q [0:`TDSM_NUM_STATES-1];
  reg [`TDSM_ENT_W-1:0] hdr_q [0:`TDSM_NUM_STATES-1];
  reg                   run_q;
  reg [`TDSM_STATE_W-1:0] def_q;
  reg [`TDSM_ENT_W-1:0] idx_q;
  reg [`TDSM_STATE_W-1:0] state_q;
  reg [`TDSM_STATE_W-1:0] state_d;
  reg                   miss_q;
  reg                   hit;
  integer               k;
  // APB strobes; slave answers in the access cycle with no waits while clk_en is high.
  // Writes are gated by pready so that a stalled setup cycle never
  // lands a write at an edge where the master does not see ready.
  wire acc = psel & penable & pready & clk_en;
  wire wr  = acc & pwrite;
  wire known = (paddr == `TDSM_CTRL_ADDR) || (paddr == `TDSM_STAT_ADDR) || (paddr == `TDSM_IDX_ADDR)
    || (paddr == `TDSM_ENT_ADDR) || (paddr == `TDSM_OUTV_ADDR) || (paddr == `TDSM_HDR_ADDR);
  wire [`TDSM_STATE_W-1:0] idx_st = idx_q[`TDSM_STATE_W-1:0];

  // Register writes; table is indexed through idx_q
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      def_q <= `TDSM_DEF_STATE;
      idx_q <= {`TDSM_ENT_W{1'b0}};
    end
    else if (wr)
    begin
      if (paddr == `TDSM_CTRL_ADDR)
      begin
        run_q <= pwdata[`TDSM_CTRL_RUN];
        def_q <= pwdata[`TDSM_CTRL_DEF_LO +: `TDSM_STATE_W];
      end
      else if (paddr == `TDSM_IDX_ADDR)
        idx_q <= pwdata[`TDSM_ENT_W-1:0];
      else if (paddr == `TDSM_ENT_ADDR)
        idx_q <= idx_q + 1'b1; // Auto increment eases bulk loading
    end
  end

  // Table arrays are cleared by reset, which also clears the valid bit of every entry
  genvar g;
  generate
    for (g = 0; g < `TDSM_NUM_ENT; g = g + 1)
    begin : g_ent
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ent_q[g] <= 32'h00000000;
        else if (wr && paddr == `TDSM_ENT_ADDR && idx_q == g)
          ent_q[g] <= pwdata;
      end
    end
    for (g = 0; g < `TDSM_NUM_STATES; g = g + 1)
    begin : g_st
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          outv_q[g] <= {OVW{1'b0}};
          hdr_q[g]  <= {`TDSM_ENT_W{1'b0}};
        end
        else if (wr && idx_st == g)
        begin
          if (paddr == `TDSM_OUTV_ADDR)
            outv_q[g] <= pwdata[OVW-1:0];
          else if (paddr == `TDSM_HDR_ADDR)
            hdr_q[g] <= pwdata[`TDSM_ENT_W-1:0];
        end
      end
    end
  endgenerate

  // Lowest matching entry owned by the present state wins; leading entry first by index order
  // Entries of one state need not be contiguous; the owner field alone ties them to it.
  // An unloaded table gives no hit, so the state simply holds.
  always @*
  begin
    state_d = state_q;
    hit = 1'b0;
    for (k = `TDSM_NUM_ENT - 1; k >= 0; k = k - 1)
    begin
      if (ent_q[k][`TDSM_ENT_VALID]
          && ent_q[k][`TDSM_ENT_OWN_LO +: `TDSM_STATE_W] == state_q
          && (((sm_in ^ ent_q[k][`TDSM_ENT_PAT_LO +: `TDSM_NUM_IN])
               & ent_q[k][`TDSM_ENT_CARE_LO +: `TDSM_NUM_IN]) == {`TDSM_NUM_IN{1'b0}}))
      begin
        state_d = ent_q[k][`TDSM_ENT_DEST_LO +: `TDSM_STATE_W];
        hit = 1'b1;
      end
    end
  end

  // State register; no match holds the state since no transition is defined
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= `TDSM_DEF_STATE;
      miss_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      // Soft reset takes the default written with it, not the old one
      if (sm_reset)
        state_q <= def_q;
      else if (wr && paddr == `TDSM_CTRL_ADDR && pwdata[`TDSM_CTRL_SRST])
        state_q <= pwdata[`TDSM_CTRL_DEF_LO +: `TDSM_STATE_W];
      else if (run_q)
      begin
        state_q <= state_d;
        miss_q  <= miss_q | ~hit;
      end
      if (wr && paddr == `TDSM_STAT_ADDR && pwdata[0] && !(run_q && !hit && !sm_reset))
        miss_q <= 1'b0; // Set wins over clear
    end
  end

  // Moore outputs registered from the present state
  // Level is passed as written even when flagged unknown;
  // whatever models the pin must honour the unknown flag first.
  generate
    for (g = 0; g < `TDSM_NUM_OUT; g = g + 1)
    begin : g_out
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          out_level[g]       <= 1'b0;
          out_unknown[g]     <= 1'b0;
          out_drive[2*g +: 2] <= `TDSM_DRV_STRONG;
        end
        else if (clk_en)
        begin
          out_level[g]        <= outv_q[state_q][`TDSM_OV_SLOT*g+`TDSM_OV_LVL];
          out_unknown[g]      <= outv_q[state_q][`TDSM_OV_SLOT*g+`TDSM_OV_UNK];
          out_drive[2*g +: 2] <= outv_q[state_q][`TDSM_OV_SLOT*g+`TDSM_OV_DRV_LO +: 2];
        end
      end
    end
  endgenerate

  // APB read data and answer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      present_state_index <= `TDSM_DEF_STATE;
    end
    else if (clk_en)
    begin
      present_state_index <= state_q;
      // Ready toggles off the select alone, so a setup edge lost to a
      // low enable is simply taken at the next enabled edge.
      // Back-to-back transfers of one master need no idle cycle; ready drops in the next setup cycle.
      pready  <= psel & ~pready;
      pslverr <= psel & ~pready & ~known;
      prdata  <= 32'h00000000;
      if (psel && !pready && !pwrite)
      begin
        if (paddr == `TDSM_CTRL_ADDR)
          prdata <= {25'h0, def_q, 3'h0, run_q};
        else if (paddr == `TDSM_STAT_ADDR)
          prdata <= {24'h0, 1'b0, state_q, 3'h0, miss_q};
        else if (paddr == `TDSM_IDX_ADDR)
          prdata <= {27'h0, idx_q};
        else if (paddr == `TDSM_ENT_ADDR)
          prdata <= ent_q[idx_q];
        else if (paddr == `TDSM_OUTV_ADDR)
          prdata <= {{(32-OVW){1'b0}}, outv_q[idx_st]};
        else if (paddr == `TDSM_HDR_ADDR)
          prdata <= {27'h0, hdr_q[idx_st]};
      end
    end
  end
endmodule // tdsm_core

// [rtl/tdsm_map.vh]
/*
  Register map, field positions, sizes and reset values of the table driven state machine.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
`ifndef TDSM_MAP_VH
`define TDSM_MAP_VH
// Sizes
`define TDSM_NUM_IN       4
`define TDSM_NUM_OUT      4
`define TDSM_NUM_STATES   8
`define TDSM_STATE_W      3
`define TDSM_NUM_ENT      32
`define TDSM_ENT_W        5
// Register byte offsets
`define TDSM_CTRL_ADDR    12'h000
`define TDSM_STAT_ADDR    12'h004
`define TDSM_IDX_ADDR     12'h008
`define TDSM_ENT_ADDR     12'h00C
`define TDSM_OUTV_ADDR    12'h010
`define TDSM_HDR_ADDR     12'h014
// Control fields
`define TDSM_CTRL_RUN     0
`define TDSM_CTRL_SRST    1
`define TDSM_CTRL_DEF_LO  4
// Entry word fields: pattern, care mask, dest, owner, valid
`define TDSM_ENT_PAT_LO   0
`define TDSM_ENT_CARE_LO  8
`define TDSM_ENT_DEST_LO  16
`define TDSM_ENT_OWN_LO   20
`define TDSM_ENT_VALID    31
// Output value: 4-bit slot per output, level [0], unknown flag [1], drive code [3:2]
`define TDSM_OV_SLOT      4
`define TDSM_OV_LVL       0
`define TDSM_OV_UNK       1
`define TDSM_OV_DRV_LO    2
`define TDSM_DRV_STRONG   2'h0
`define TDSM_DRV_RESIST   2'h1
`define TDSM_DRV_HIZ      2'h2
`define TDSM_DRV_UNDEF    2'h3
// Reset values
`define TDSM_DEF_STATE    3'h0
// Clock to output delay, ns and cycles at 5 ns
`define TDSM_CLK_DELAY_NS 1
`define TDSM_CLK_PERIOD_NS 5
`define TDSM_CLK_DELAY_CYC ((`TDSM_CLK_DELAY_NS + `TDSM_CLK_PERIOD_NS - 1) / `TDSM_CLK_PERIOD_NS)
`endif

// [testbench/tdsm_asserts.sv]
/* Port checker for tdsm_core.
   Assumes a bind onto tdsm_core, one clock pclk. */
`timescale 1ns/100ps
`include "tdsm_map.vh"
module tdsm_asserts (
  // Clock and reset
  input wire                       pclk,
  input wire                       presetn,
  input wire                       clk_en,
  // APB
  input wire                       psel,
  input wire                       penable,
  input wire [31:0]                prdata,
  input wire                       pready,
  input wire                       pslverr,
  // Machine
  input wire [`TDSM_NUM_OUT-1:0]   out_level,
  input wire [2*`TDSM_NUM_OUT-1:0] out_drive,
  input wire [`TDSM_STATE_W-1:0]   present_state_index
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Loading path answers in one cycle, one pulse
  AST_READY_NEXT: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready");
  AST_READY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("ready held");
  AST_READY_CAUSE: assert property ($rose(pready) |-> $past(psel) && $past(clk_en))
    else $error("stray ready");
  AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0)
    else $error("stray rdata");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("lone error");
  AST_RST_STATE: assert property ($rose(presetn) |-> present_state_index == 3'h0 && out_level == 4'h0)
    else $error("bad reset state");
  // Frozen enable must freeze the state index and drive pins too
  AST_STALL: assert property (!clk_en |=> $stable(present_state_index) && $stable(out_drive))
    else $error("moved on stall");
  // Outputs follow the state only, bus writes excluded
  AST_MOORE: assert property (!psel && !$past(psel) && $stable(present_state_index)
    |-> $stable(out_level) && $stable(out_drive))
    else $error("output without state");
  C_MOVE: cover property ($changed(present_state_index));
  C_ERR: cover property (pslverr);
  C_STALL: cover property (!clk_en);
endmodule // tdsm_asserts

// [testbench/tdsm_env.sv]
/* Surrounding logic model: drives machine inputs, sync reset, enable.
   Assumes the bench calls apply from its own process. */
`timescale 1ns/100ps
module tdsm_env (
  // Clock
  input  wire        pclk,
  // Machine drive
  output logic [3:0] sm_in,
  output logic       sm_reset,
  output logic       clk_en
);
  // Quiet, enabled machine at time zero
  initial
  begin
    sm_in = 4'h0;
    sm_reset = 1'b0;
    clk_en = 1'b1;
  end
  // Change after an edge so the core samples a settled value
  task apply(input logic [3:0] i, input logic r, input logic e);
    @(posedge pclk);
    sm_in <= i;
    sm_reset <= r;
    clk_en <= e;
  endtask
endmodule // tdsm_env

// [testbench/tdsm_core_bench.sv]
/* Bench for tdsm_core: loads a table over APB, runs the machine.
   Assumes tdsm_env drives the machine pins. */
`timescale 1ns/100ps
`include "tdsm_map.vh"
module tdsm_core_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sm_reset, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sm_in, out_level, out_unknown;
  logic [7:0]  out_drive;
  logic [2:0]  present_state_index;
  int          error_cnt, total_checks;
  tdsm_core tdsm_core_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sm_in(sm_in), .sm_reset(sm_reset), .out_level(out_level), .out_unknown(out_unknown), .out_drive(out_drive),
    .present_state_index(present_state_index));
  tdsm_env tdsm_env_i (.pclk(pclk), .sm_in(sm_in), .sm_reset(sm_reset), .clk_en(clk_en));
  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready, no fixed latency assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Inputs land, state moves next edge, pins one edge later
  task step(input logic [3:0] i, input logic r, input logic e);
    tdsm_env_i.apply(i, r, e);
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task t_load;
    apb(1'b1, `TDSM_IDX_ADDR, 32'h0);
    apb(1'b1, `TDSM_ENT_ADDR, 32'h80010808);
    apb(1'b1, `TDSM_ENT_ADDR, 32'h80120F00);
    apb(1'b1, `TDSM_IDX_ADDR, 32'h1);
    apb(1'b1, `TDSM_OUTV_ADDR, 32'h0000AD51);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, `TDSM_CTRL_ADDR, 32'h1);
    $display("load done");
  endtask
  task t_run;
    step(4'h7, 1'b0, 1'b1);
    chk(present_state_index, 32'h0);
    step(4'hB, 1'b0, 1'b0);
    chk(present_state_index, 32'h0);
    step(4'hB, 1'b0, 1'b1);
    chk({out_unknown, out_drive, out_level, present_state_index}, 32'h00045A39);
    step(4'h1, 1'b0, 1'b1);
    apb(1'b0, `TDSM_STAT_ADDR, 32'h0);
    chk(rd & 32'h71, 32'h11);
    step(4'h0, 1'b0, 1'b1);
    chk({out_unknown, out_drive, out_level, present_state_index}, 32'h2);
    $display("run done");
  endtask
  task t_reset;
    apb(1'b1, `TDSM_CTRL_ADDR, 32'h31);
    step(4'h0, 1'b1, 1'b1);
    chk(present_state_index, 32'h3);
    step(4'h0, 1'b0, 1'b1);
    apb(1'b1, `TDSM_CTRL_ADDR, 32'h12);
    @(posedge pclk);
    #1;
    chk(present_state_index, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({out_unknown, out_drive, out_level, present_state_index}, 32'h0);
    $display("reset done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence, reset held two cycles
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = 0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_load;
    t_run;
    t_reset;
    finish_test;
  end
  // Watchdog, tests need well under 1000 cycles
  initial
  begin
    #5000;
    error_cnt++;
    finish_test;
  end
endmodule // tdsm_core_bench
bind tdsm_core tdsm_asserts tdsm_asserts_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_level(out_level),
  .out_drive(out_drive), .present_state_index(present_state_index));
